// File: logic/rcs_pkg.sv
package rcs_pkg;

  // register indices on the multiplexed bus
  localparam logic [7:0] RCS_ADDR_CONTROL = 8'h0b;
  localparam logic [7:0] RCS_ADDR_FLAGS = 8'h0c;
  localparam logic [7:0] RCS_ADDR_VALID = 8'h0d;

  localparam int RCS_NUM_TAPS = 15;
  localparam logic [3:0] RCS_RATE_OFF = 4'h0;

  localparam logic [7:0] RCS_BYTE_ZERO = 8'h00;
  localparam logic [7:0] RCS_DONT_CARE_MASK = 8'hc0;

  // daylight-savings calendar points, as plain decimal values
  localparam logic [7:0] RCS_DST_SECMIN = 8'h3b;
  localparam logic [7:0] RCS_DST_HOUR = 8'h01;
  localparam logic [7:0] RCS_SUNDAY = 8'h01;
  localparam logic [7:0] RCS_APRIL = 8'h04;
  localparam logic [7:0] RCS_OCTOBER = 8'h0a;
  localparam logic [7:0] RCS_LAST_WEEK_DATE = 8'h19;

  typedef struct packed {
    logic freeze;
    logic periodic_irq_enable;
    logic alarm_irq_enable;
    logic update_ended_irq_enable;
    logic square_wave_enable;
    logic data_format_select;
    logic hour_24_select;
    logic daylight_savings_enable;
  } rcs_ctrl_s;

  typedef struct packed {
    logic periodic_flag;
    logic alarm_flag;
    logic update_ended_flag;
  } rcs_flags_s;

  typedef struct packed {
    logic [7:0] seconds;
    logic [7:0] minutes;
    logic [7:0] hours;
  } rcs_hms_s;

  typedef struct packed {
    rcs_hms_s hms;
    logic [7:0] day_of_week;
    logic [7:0] date;
    logic [7:0] month;
  } rcs_time_s;

  localparam rcs_ctrl_s RCS_CTRL_RESET = '0;
  localparam rcs_flags_s RCS_FLAGS_RESET = '0;

  typedef enum logic [1:0] {
    RCS_BUS_IDLE = 2'b00,
    RCS_BUS_ADDR = 2'b01,
    RCS_BUS_DATA = 2'b11
  } rcs_bus_state_e;

endpackage

// File: logic/rcs_sync.sv
`timescale 1ns/10ps
module rcs_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_q;
      logic stable_q;
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          meta_q <= 1'b0;
          stable_q <= 1'b0;
        end else if (clk_en) begin
          meta_q <= async_in[i];
          stable_q <= meta_q;
        end
      end
      assign sync_out[i] = stable_q;
    end
  endgenerate
endmodule

// File: logic/rcs_tap.sv
`timescale 1ns/10ps
module rcs_tap
  import rcs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [rcs_pkg::RCS_NUM_TAPS-1:0] div_taps,
  input wire logic [3:0] rate_select,
  output logic tap_level,
  output logic tap_rise
);
  logic sel_d;
  logic level_q;

  always_comb begin
    sel_d = 1'b0;
    if (rate_select != RCS_RATE_OFF) begin
      sel_d = div_taps[rate_select - 4'h1];
    end
  end

  // a rate change may itself make one extra edge; that matches the divider
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      level_q <= 1'b0;
    end else if (clk_en) begin
      level_q <= sel_d;
    end
  end

  assign tap_level = level_q;
  assign tap_rise = sel_d & ~level_q;
endmodule

// File: logic/rcs_regs.sv
`timescale 1ns/10ps
// What this block does
// - freeze bit stops updates, aborts one running
// - freeze bit readable, writable, reset-pin immune
// - periodic flag sets regardless of its enable
// - reset pin clears irq and square enables
// - alarm per matching second, 11xxxxxx matches all
// - update-ended enable cleared by reset, freeze rise
// - square pin follows tap when enabled, else low
// - data format: 1 binary, 0 BCD, software only
// - hour format: 1 24-hour, 0 12-hour
// - april last sunday 1:59:59 jumps to 3:00:00
// - october last sunday 1:59:59 back once
// - no dst steps when disabled; enable keeps
// - irq flag ORs each flag ANDed with its enable
// - irq pin low while irq flag set
// - flag register read or reset clears flags
// - periodic flag set on selected tap edge
// - update-ended flag set after each update
// - flag register low nibble reads zero
// - valid bit zero after power-sense low
// - valid bit read-only, set by reading it
// - validity register low seven bits zero
// - freeze write inhibits updates, clears in-progress
module rcs_regs
  import rcs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic reset_pin_n,
  input wire logic power_sense_pin,
  input wire logic bus_as,
  input wire logic bus_ds,
  input wire logic bus_rw,
  input wire logic bus_cs_n,
  input wire logic [7:0] bus_ad_in,
  output logic [7:0] bus_ad_out,
  output logic bus_ad_oe_n,
  output logic irq_n,
  output logic square_wave_pin,
  input wire logic [rcs_pkg::RCS_NUM_TAPS-1:0] div_taps,
  input wire logic [3:0] rate_select,
  input wire logic update_done,
  input wire rcs_pkg::rcs_time_s time_now,
  input wire rcs_pkg::rcs_hms_s alarm_set,
  output logic update_enable,
  output logic update_abort,
  output logic data_format_select,
  output logic hour_24_select,
  output logic dst_jump_forward,
  output logic dst_step_back
);
  import rcs_pkg::*;

  // pin synchronisers; only the second stage is read below
  logic [11:0] pins_sync;
  logic rst_pin_n_s;
  logic pwr_ok_s;
  logic as_s;
  logic ds_s;
  logic rw_s;
  logic cs_n_s;
  logic [7:0] ad_s;

  rcs_sync #(.W(14)) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clk_en(clk_en),
    .async_in({reset_pin_n, power_sense_pin, bus_as, bus_ds, bus_rw,
               bus_cs_n, bus_ad_in}),
    .sync_out({rst_pin_n_s, pwr_ok_s, pins_sync})
  );

  assign as_s = pins_sync[11];
  assign ds_s = pins_sync[10];
  assign rw_s = pins_sync[9];
  assign cs_n_s = pins_sync[8];
  assign ad_s = pins_sync[7:0];

  logic tap_level;
  logic tap_rise;

  rcs_tap u_tap (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clk_en(clk_en),
    .div_taps(div_taps),
    .rate_select(rate_select),
    .tap_level(tap_level),
    .tap_rise(tap_rise)
  );

  // ---------------- multiplexed bus --------------------------------
  rcs_bus_state_e bus_q;
  rcs_bus_state_e bus_d;
  logic as_prev_q;
  logic ds_prev_q;
  logic [7:0] addr_q;
  logic sel_q;
  logic [7:0] rdata_q;
  logic drive_q;
  rcs_flags_s flags_seen_q;
  logic as_fall;
  logic ds_rise;
  logic ds_fall;
  logic wr_ctrl;
  logic rd_done_flags;
  logic rd_done_valid;

  assign as_fall = as_prev_q & ~as_s;
  assign ds_rise = ds_s & ~ds_prev_q;
  assign ds_fall = ds_prev_q & ~ds_s;

  always_comb begin
    bus_d = bus_q;
    case (bus_q)
      RCS_BUS_IDLE: begin
        if (as_s) begin
          bus_d = RCS_BUS_ADDR;
        end
      end
      RCS_BUS_ADDR: begin
        if (as_fall) begin
          bus_d = RCS_BUS_DATA;
        end
      end
      RCS_BUS_DATA: begin
        if (ds_fall || as_s) begin
          bus_d = as_s ? RCS_BUS_ADDR : RCS_BUS_IDLE;
        end
      end
      default: bus_d = RCS_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bus_q <= RCS_BUS_IDLE;
      as_prev_q <= 1'b0;
      ds_prev_q <= 1'b0;
    end else if (clk_en) begin
      bus_q <= bus_d;
      as_prev_q <= as_s;
      ds_prev_q <= ds_s;
    end
  end

  // address and chip select are taken as address strobe falls
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      addr_q <= RCS_BYTE_ZERO;
      sel_q <= 1'b0;
    end else if (clk_en && bus_q == RCS_BUS_ADDR && as_fall) begin
      addr_q <= ad_s;
      sel_q <= ~cs_n_s;
    end
  end

  logic data_phase;
  logic my_addr;
  assign data_phase = (bus_q == RCS_BUS_DATA) && sel_q;
  assign my_addr = (addr_q == RCS_ADDR_CONTROL) ||
                   (addr_q == RCS_ADDR_FLAGS) ||
                   (addr_q == RCS_ADDR_VALID);
  // writes to flag and validity registers store nothing
  assign wr_ctrl = data_phase && ds_fall && !rw_s &&
                   addr_q == RCS_ADDR_CONTROL;
  assign rd_done_flags = data_phase && ds_fall && rw_s &&
                         addr_q == RCS_ADDR_FLAGS;
  assign rd_done_valid = data_phase && ds_fall && rw_s &&
                         addr_q == RCS_ADDR_VALID;

  // ---------------- control register -------------------------------
  rcs_ctrl_s ctrl_q;
  rcs_ctrl_s wdata;
  logic freeze_rise;
  assign wdata = rcs_ctrl_s'(ad_s);
  assign freeze_rise = wr_ctrl & wdata.freeze & ~ctrl_q.freeze;

  // power-on reset only: the reset pin leaves these alone
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_q.freeze <= RCS_CTRL_RESET.freeze;
      ctrl_q.data_format_select <= RCS_CTRL_RESET.data_format_select;
      ctrl_q.hour_24_select <= RCS_CTRL_RESET.hour_24_select;
      ctrl_q.daylight_savings_enable <=
        RCS_CTRL_RESET.daylight_savings_enable;
    end else if (clk_en && wr_ctrl) begin
      ctrl_q.freeze <= wdata.freeze;
      ctrl_q.data_format_select <= wdata.data_format_select;
      ctrl_q.hour_24_select <= wdata.hour_24_select;
      ctrl_q.daylight_savings_enable <=
        wdata.daylight_savings_enable;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_q.periodic_irq_enable <= RCS_CTRL_RESET.periodic_irq_enable;
      ctrl_q.alarm_irq_enable <= RCS_CTRL_RESET.alarm_irq_enable;
      ctrl_q.update_ended_irq_enable <=
        RCS_CTRL_RESET.update_ended_irq_enable;
      ctrl_q.square_wave_enable <= RCS_CTRL_RESET.square_wave_enable;
    end else if (clk_en) begin
      if (!rst_pin_n_s) begin
        ctrl_q.periodic_irq_enable <= 1'b0;
        ctrl_q.alarm_irq_enable <= 1'b0;
        ctrl_q.update_ended_irq_enable <= 1'b0;
        ctrl_q.square_wave_enable <= 1'b0;
      end else if (wr_ctrl) begin
        ctrl_q.periodic_irq_enable <= wdata.periodic_irq_enable;
        ctrl_q.alarm_irq_enable <= wdata.alarm_irq_enable;
        // freeze going high in the same write wins over the enable
        ctrl_q.update_ended_irq_enable <=
          wdata.update_ended_irq_enable & ~freeze_rise;
        ctrl_q.square_wave_enable <= wdata.square_wave_enable;
      end
    end
  end

  assign update_enable = ~ctrl_q.freeze;
  assign data_format_select = ctrl_q.data_format_select;
  assign hour_24_select = ctrl_q.hour_24_select;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      update_abort <= 1'b0;
    end else if (clk_en) begin
      update_abort <= freeze_rise;
    end
  end

  // ---------------- square wave ------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      square_wave_pin <= 1'b0;
    end else if (clk_en) begin
      square_wave_pin <= ctrl_q.square_wave_enable & tap_level;
    end
  end

  // ---------------- alarm compare ----------------------------------
  function automatic logic byte_match(logic [7:0] t, logic [7:0] a);
    byte_match = (t == a) ||
      ((a & RCS_DONT_CARE_MASK) == RCS_DONT_CARE_MASK);
  endfunction

  logic alarm_hit;
  assign alarm_hit = update_done &&
    byte_match(time_now.hms.seconds, alarm_set.seconds) &&
    byte_match(time_now.hms.minutes, alarm_set.minutes) &&
    byte_match(time_now.hms.hours, alarm_set.hours);

  // ---------------- flags ------------------------------------------
  rcs_flags_s flags_q;
  rcs_flags_s flags_set;
  rcs_flags_s flags_clr;
  logic irq_flag;

  assign flags_set.periodic_flag = tap_rise;
  assign flags_set.alarm_flag = alarm_hit;
  assign flags_set.update_ended_flag = update_done;
  // only flags that the read returned are cleared; later ones survive
  assign flags_clr = rd_done_flags ? flags_seen_q : RCS_FLAGS_RESET;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flags_q <= RCS_FLAGS_RESET;
    end else if (clk_en) begin
      if (!rst_pin_n_s) begin
        flags_q <= RCS_FLAGS_RESET;
      end else begin
        flags_q <= (flags_q & ~flags_clr) | flags_set;
      end
    end
  end

  assign irq_flag = (flags_q.periodic_flag & ctrl_q.periodic_irq_enable) |
                (flags_q.alarm_flag & ctrl_q.alarm_irq_enable) |
                (flags_q.update_ended_flag &
                 ctrl_q.update_ended_irq_enable);
  assign irq_n = ~irq_flag;

  // ---------------- validity bit -----------------------------------
  logic ram_valid_bit_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ram_valid_bit_q <= 1'b0;
    end else if (clk_en) begin
      if (!pwr_ok_s) begin
        ram_valid_bit_q <= 1'b0;
      end else if (rd_done_valid) begin
        ram_valid_bit_q <= 1'b1;
      end
    end
  end

  // ---------------- read data --------------------------------------
  logic [7:0] rmux;
  always_comb begin
    rmux = RCS_BYTE_ZERO;
    case (addr_q)
      RCS_ADDR_CONTROL: rmux = ctrl_q;
      RCS_ADDR_FLAGS: rmux = {irq_flag, flags_q, 4'h0};
      RCS_ADDR_VALID: rmux = {ram_valid_bit_q, 7'h00};
      default: rmux = RCS_BYTE_ZERO;
    endcase
  end

  // read data is captured as data strobe rises and held to its fall
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= RCS_BYTE_ZERO;
      flags_seen_q <= RCS_FLAGS_RESET;
      drive_q <= 1'b0;
    end else if (clk_en) begin
      if (data_phase && ds_rise && rw_s && my_addr) begin
        rdata_q <= rmux;
        flags_seen_q <= flags_q;
        drive_q <= 1'b1;
      end else if (ds_fall || bus_q != RCS_BUS_DATA) begin
        drive_q <= 1'b0;
      end
    end
  end

  assign bus_ad_out = rdata_q;
  assign bus_ad_oe_n = ~drive_q;

  // ---------------- daylight savings -------------------------------
  function automatic logic [7:0] fmt(logic bin, logic [7:0] v);
    logic [7:0] tens;
    logic [7:0] ones;
    tens = v / 8'd10;
    ones = v % 8'd10;
    fmt = bin ? v : {tens[3:0], ones[3:0]};
  endfunction

  logic bin_mode;
  logic at_159;
  logic last_sunday;
  logic in_april;
  logic in_october;
  logic fall_done_q;
  assign bin_mode = ctrl_q.data_format_select;
  // hour byte 1 is 1 AM in both hour formats: the PM bit is clear
  assign at_159 =
    time_now.hms.seconds == fmt(bin_mode, RCS_DST_SECMIN) &&
    time_now.hms.minutes == fmt(bin_mode, RCS_DST_SECMIN) &&
    time_now.hms.hours == fmt(bin_mode, RCS_DST_HOUR);
  assign last_sunday = time_now.day_of_week == fmt(bin_mode, RCS_SUNDAY) &&
    time_now.date >= fmt(bin_mode, RCS_LAST_WEEK_DATE);
  assign in_april = time_now.month == fmt(bin_mode, RCS_APRIL);
  assign in_october = time_now.month == fmt(bin_mode, RCS_OCTOBER);

  assign dst_jump_forward = ctrl_q.daylight_savings_enable &&
    at_159 && last_sunday && in_april;
  assign dst_step_back = ctrl_q.daylight_savings_enable &&
    at_159 && last_sunday && in_october && !fall_done_q;

  // remembers the one fall-back step until the day is over
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fall_done_q <= 1'b0;
    end else if (clk_en) begin
      if (update_done && dst_step_back) begin
        fall_done_q <= 1'b1;
      end else if (!(last_sunday && in_october)) begin
        fall_done_q <= 1'b0;
      end
    end
  end

endmodule

// File: dv/rcs_regs_properties.sv
`timescale 1ns/10ps
module rcs_regs_properties (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic reset_pin_n,
  input wire logic bus_as,
  input wire logic bus_ds,
  input wire logic bus_rw,
  input wire logic bus_cs_n,
  input wire logic [7:0] bus_ad_in,
  input wire logic [7:0] bus_ad_out,
  input wire logic bus_ad_oe_n,
  input wire logic irq_n,
  input wire logic square_wave_pin,
  input wire logic [rcs_pkg::RCS_NUM_TAPS-1:0] div_taps,
  input wire logic [3:0] rate_select,
  input wire rcs_pkg::rcs_time_s time_now,
  input wire logic update_enable,
  input wire logic update_abort,
  input wire logic data_format_select,
  input wire logic hour_24_select,
  input wire logic dst_jump_forward,
  input wire logic dst_step_back
);
  import rcs_pkg::*;
  logic [7:0] addr_q;
  logic [3:0] ds_age_q;
  logic tap_sel;
  assign tap_sel = (rate_select == RCS_RATE_OFF) ? 1'b0 :
    div_taps[rate_select - 4'h1];
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      addr_q <= RCS_BYTE_ZERO;
    end else if (bus_as && !bus_cs_n) begin
      addr_q <= bus_ad_in;
    end
  end
  // cycles since the data strobe was last high, saturating
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ds_age_q <= 4'hf;
    end else if (bus_ds) begin
      ds_age_q <= 4'h0;
    end else if (ds_age_q != 4'hf) begin
      ds_age_q <= ds_age_q + 4'h1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  square_follows_tap_a: assert property (
    square_wave_pin |-> $past(tap_sel, 2))
    else $error("square pin high without selected tap");
  read_drive_only_a: assert property (
    !bus_ad_oe_n |-> bus_rw && addr_q inside {8'h0b, 8'h0c, 8'h0d})
    else $error("bus driven outside a register read");
  answer_delay_a: assert property (
    $fell(bus_ad_oe_n) |-> $past(bus_ds, 3))
    else $error("read answer at wrong time");
  flags_low_zero_a: assert property (
    !bus_ad_oe_n && addr_q == RCS_ADDR_FLAGS |-> bus_ad_out[3:0] == 4'h0)
    else $error("flag register low bits not zero");
  valid_low_zero_a: assert property (
    !bus_ad_oe_n && addr_q == RCS_ADDR_VALID |-> bus_ad_out[6:0] == 7'h00)
    else $error("validity register low bits not zero");
  abort_freezes_a: assert property (
    update_abort |-> ##[0:1] !update_enable)
    else $error("abort without freeze");
  abort_single_a: assert property (
    update_abort |=> !update_abort)
    else $error("abort pulse longer than one cycle");
  freeze_aborts_a: assert property (
    $fell(update_enable) |-> update_abort)
    else $error("freeze raised without abort pulse");
  soft_only_change_a: assert property (
    $changed({update_enable, data_format_select, hour_24_select})
      |-> ds_age_q < 4'h8)
    else $error("format or freeze changed without a write");
  reset_pin_quiet_a: assert property (
    !reset_pin_n [*6] |-> irq_n && !square_wave_pin)
    else $error("irq or square active under reset pin");
  dst_exclusive_a: assert property (
    !(dst_jump_forward && dst_step_back))
    else $error("both daylight steps requested");
  dst_april_only_a: assert property (
    dst_jump_forward |-> time_now.month == RCS_APRIL ||
      $past(time_now.month) == RCS_APRIL)
    else $error("forward jump outside april");
endmodule

bind rcs_regs rcs_regs_properties chk_i (.clk_sys, .nrst, .reset_pin_n,
  .bus_as, .bus_ds, .bus_rw, .bus_cs_n, .bus_ad_in, .bus_ad_out,
  .bus_ad_oe_n, .irq_n, .square_wave_pin, .div_taps, .rate_select,
  .time_now, .update_enable, .update_abort, .data_format_select,
  .hour_24_select, .dst_jump_forward, .dst_step_back);

// File: dv/rcs_cpu_model.sv
`timescale 1ns/10ps
module rcs_cpu_model (
  input wire logic clk_sys,
  input wire logic [7:0] bus_ad_out,
  input wire logic bus_ad_oe_n,
  output logic bus_as,
  output logic bus_ds,
  output logic bus_rw,
  output logic bus_cs_n,
  output logic [7:0] bus_ad_in
);
  initial begin
    bus_as = 1'b0;
    bus_ds = 1'b0;
    bus_rw = 1'b1;
    bus_cs_n = 1'b1;
    bus_ad_in = 8'h00;
  end
  // each phase held 4+ clocks: the block sees the bus through synchronisers
  task automatic access(input logic [7:0] addr, input logic wr,
    input logic [7:0] wdata, output logic [7:0] rdata, output logic drove);
    rdata = 8'h00;
    drove = 1'b0;
    @(posedge clk_sys);
    bus_cs_n <= 1'b0;
    bus_as <= 1'b1;
    bus_rw <= !wr;
    bus_ad_in <= addr;
    repeat (4) @(posedge clk_sys);
    bus_as <= 1'b0;
    repeat (4) @(posedge clk_sys);
    bus_ds <= 1'b1;
    // a read drives the inverted address on AD, so no stale address lingers here
    bus_ad_in <= wr ? wdata : ~addr;
    repeat (8) begin
      @(posedge clk_sys);
      if (bus_ad_oe_n === 1'b0) begin
        drove = 1'b1;
        rdata = bus_ad_out;
      end
    end
    bus_ds <= 1'b0;
    repeat (4) @(posedge clk_sys);
    bus_cs_n <= 1'b1;
    bus_ad_in <= ~bus_ad_in;
  endtask
endmodule

// File: dv/rcs_regs_tb.sv
`timescale 1ns/10ps
module rcs_regs_tb;
  import rcs_pkg::*;
  localparam int TIMEOUT = 20000;
  logic clk_sys = 1'b0;
  logic nrst, clk_en, reset_pin_n, power_sense_pin, update_done;
  logic bus_as, bus_ds, bus_rw, bus_cs_n, bus_ad_oe_n, irq_n;
  logic square_wave_pin, update_enable, update_abort, data_format_select;
  logic hour_24_select, dst_jump_forward, dst_step_back, drove;
  logic [7:0] bus_ad_in, bus_ad_out, rdat;
  logic [RCS_NUM_TAPS-1:0] div_taps;
  logic [3:0] rate_select;
  rcs_time_s time_now;
  rcs_hms_s alarm_set;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #25 clk_sys = ~clk_sys;

  rcs_cpu_model cpu (.clk_sys, .bus_ad_out, .bus_ad_oe_n, .bus_as, .bus_ds,
    .bus_rw, .bus_cs_n, .bus_ad_in);
  rcs_regs dut (.clk_sys, .nrst, .clk_en, .reset_pin_n, .power_sense_pin,
    .bus_as, .bus_ds, .bus_rw, .bus_cs_n, .bus_ad_in, .bus_ad_out,
    .bus_ad_oe_n, .irq_n, .square_wave_pin, .div_taps, .rate_select,
    .update_done, .time_now, .alarm_set, .update_enable, .update_abort,
    .data_format_select, .hour_24_select, .dst_jump_forward, .dst_step_back);

  task automatic chk(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    cpu.access(a, 1'b0, 8'h00, rdat, drove);
    chk($sformatf("register %h", a), rdat, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cpu.access(a, 1'b1, d, rdat, drove);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic pulse_upd();
    @(posedge clk_sys);
    update_done <= 1'b1;
    @(posedge clk_sys);
    update_done <= 1'b0;
    tick(3);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == TIMEOUT) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    nrst = 1'b0;
    clk_en = 1'b1;
    reset_pin_n = 1'b1;
    power_sense_pin = 1'b1;
    update_done = 1'b0;
    div_taps = '0;
    rate_select = 4'h0;
    time_now = '0;
    alarm_set = {8'h11, 8'h22, 8'h33};
    tick(10);
    nrst <= 1'b1;
    rc(RCS_ADDR_CONTROL, 8'h00);
    rc(RCS_ADDR_FLAGS, 8'h00);
    rc(RCS_ADDR_VALID, 8'h00);
    rc(RCS_ADDR_VALID, 8'h80);
    $display("test reset values done");
    wr(RCS_ADDR_CONTROL, 8'h7f);
    rc(RCS_ADDR_CONTROL, 8'h7f);
    chk("data format", {7'h00, data_format_select}, 8'h01);
    chk("hour format", {7'h00, hour_24_select}, 8'h01);
    chk("update enable", {7'h00, update_enable}, 8'h01);
    pulse_upd();
    chk("irq pin", {7'h00, irq_n}, 8'h00);
    rc(RCS_ADDR_FLAGS, 8'h90);
    rc(RCS_ADDR_FLAGS, 8'h00);
    chk("irq pin", {7'h00, irq_n}, 8'h01);
    alarm_set <= {8'hc0, 8'hff, 8'hc3};
    pulse_upd();
    rc(RCS_ADDR_FLAGS, 8'hb0);
    $display("test update and alarm done");
    rate_select <= 4'h3;
    div_taps <= 15'h0004;
    tick(4);
    chk("square pin", {7'h00, square_wave_pin}, 8'h01);
    div_taps <= '0;
    rc(RCS_ADDR_FLAGS, 8'hc0);
    wr(RCS_ADDR_CONTROL, 8'h37);
    div_taps <= 15'h0004;
    tick(4);
    chk("square pin", {7'h00, square_wave_pin}, 8'h00);
    chk("irq pin", {7'h00, irq_n}, 8'h01);
    div_taps <= '0;
    rc(RCS_ADDR_FLAGS, 8'h40);
    $display("test periodic and square done");
    wr(RCS_ADDR_CONTROL, 8'hff);
    rc(RCS_ADDR_CONTROL, 8'hef);
    chk("update enable", {7'h00, update_enable}, 8'h00);
    pulse_upd();
    reset_pin_n <= 1'b0;
    tick(6);
    reset_pin_n <= 1'b1;
    tick(4);
    chk("irq pin", {7'h00, irq_n}, 8'h01);
    rc(RCS_ADDR_CONTROL, 8'h87);
    rc(RCS_ADDR_FLAGS, 8'h00);
    rc(RCS_ADDR_VALID, 8'h80);
    $display("test freeze and reset pin done");
    power_sense_pin <= 1'b0;
    tick(5);
    power_sense_pin <= 1'b1;
    tick(4);
    rc(RCS_ADDR_VALID, 8'h00);
    wr(RCS_ADDR_FLAGS, 8'hff);
    wr(RCS_ADDR_VALID, 8'h00);
    rc(RCS_ADDR_VALID, 8'h80);
    rc(RCS_ADDR_FLAGS, 8'h00);
    cpu.access(8'h0e, 1'b0, 8'h00, rdat, drove);
    chk("unmapped drive", {7'h00, drove}, 8'h00);
    $display("test validity and refusals done");
    wr(RCS_ADDR_CONTROL, 8'h07);
    time_now <= {8'h3b, 8'h3b, 8'h01, 8'h01, 8'h19, 8'h04};
    tick(3);
    chk("forward jump", {7'h00, dst_jump_forward}, 8'h01);
    time_now.month <= RCS_OCTOBER;
    tick(3);
    chk("step back", {7'h00, dst_step_back}, 8'h01);
    pulse_upd();
    chk("step back once", {7'h00, dst_step_back}, 8'h00);
    wr(RCS_ADDR_CONTROL, 8'h06);
    time_now.month <= RCS_APRIL;
    tick(3);
    chk("forward off", {7'h00, dst_jump_forward}, 8'h00);
    wr(RCS_ADDR_CONTROL, 8'h01);
    time_now <= {8'h59, 8'h59, 8'h01, 8'h01, 8'h25, 8'h04};
    tick(3);
    chk("bcd jump", {7'h00, dst_jump_forward}, 8'h01);
    $display("test daylight savings done");
    end_sim();
  end
endmodule
